// *** verilog/ssce_cfg.svh ***
// Bit positions, markers and timing defaults of the serial shift command engine.
`ifndef SSCE_CFG_SVH
`define SSCE_CFG_SVH

// Field positions inside a shifting opcode byte.
`define SSCE_OP_NEG_WR 0
`define SSCE_OP_BITMODE 1
`define SSCE_OP_NEG_RD 2
`define SSCE_OP_LSB 3
`define SSCE_OP_DO_WR 4
`define SSCE_OP_DO_RD 5
`define SSCE_OP_DO_SEL 6
`define SSCE_OP_TOP 7

// First byte of the two-byte answer to a bad opcode.
`define SSCE_ERR_MARK 8'hFA

// Bit count minus one of a whole byte job.
`define SSCE_BYTE_BITS 3'h7

// Reset value of the response register and of shift registers.
`define SSCE_BYTE_RST 8'h00

// Link clock cycles per serial clock half period.
`define SSCE_HALF_CYC 4

`endif

// *** verilog/ssce_pkg.sv ***
// Types shared by the serial shift command engine and its link shifter.
`default_nettype none
package ssce_pkg;

  typedef logic [7:0] ssce_byte_t;

  // Command interpreter states, one-hot.
  typedef enum logic [7:0] {
    SS_OP   = 8'h01,
    SS_LENL = 8'h02,
    SS_LENH = 8'h04,
    SS_DATA = 8'h08,
    SS_RUN  = 8'h10,
    SS_RESP = 8'h20,
    SS_ERR1 = 8'h40,
    SS_ERR2 = 8'h80
  } ssce_state_t;

  // Link shifter states, one-hot.
  typedef enum logic [1:0] {
    SL_IDLE  = 2'h1,
    SL_SHIFT = 2'h2
  } ssce_link_state_t;

endpackage : ssce_pkg
`default_nettype wire

// *** verilog/ssce_shifter.sv ***
// Link-clock shifter: runs one job of one to eight bits on the serial pins.
`timescale 1ns/1ps
`default_nettype none
`include "ssce_cfg.svh"
module ssce_shifter #(
  parameter int HALF_CYC = `SSCE_HALF_CYC
) (
  input wire logic link_clk_in,
  input wire logic rst_n_in,
  input wire logic req_tgl_in,
  input wire ssce_pkg::ssce_byte_t job_data_in,
  input wire logic [2:0] job_bits_in,
  input wire logic op_neg_wr_in,
  input wire logic op_neg_rd_in,
  input wire logic op_lsb_in,
  input wire logic op_wr_in,
  input wire logic op_rd_in,
  input wire logic idle_high_in,
  input wire logic serial_data_in,
  output logic ack_tgl_out,
  output ssce_pkg::ssce_byte_t rx_byte_out,
  output logic serial_clock_out,
  output logic serial_data_out
);
  import ssce_pkg::*;

  localparam int PW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [PW-1:0] PH_LOAD = PW'(HALF_CYC - 1);

  // The synchronised input lags by two link cycles, so a half period
  // shorter than three cycles would sample stale data.
  generate
    if (HALF_CYC < 3) begin : g_bad_half
      $error("HALF_CYC must be at least 3");
    end
  endgenerate

  ssce_link_state_t st_ff;
  logic req_m_ff, req_s_ff, req_d_ff;
  logic idle_m_ff, idle_s_ff;
  logic din_m_ff, din_s_ff;
  logic [PW-1:0] ph_ff;
  logic [4:0] edges_ff;
  logic sclk_ff, lvl_ff, dout_ff;
  ssce_byte_t sh_ff, rx_ff;
  logic start, tick, rising, cap, adv, done;
  ssce_byte_t nxt_rx, nxt_sh;
  logic nxt_bit;

  // Two-flop synchronisers for the job toggle, idle level and data pin.
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_m_ff <= 1'b0;
      req_s_ff <= 1'b0;
      req_d_ff <= 1'b0;
      idle_m_ff <= 1'b0;
      idle_s_ff <= 1'b0;
      din_m_ff <= 1'b0;
      din_s_ff <= 1'b0;
    end else begin
      req_m_ff <= req_tgl_in;
      req_s_ff <= req_m_ff;
      req_d_ff <= req_s_ff;
      idle_m_ff <= idle_high_in;
      idle_s_ff <= idle_m_ff;
      din_m_ff <= serial_data_in;
      din_s_ff <= din_m_ff;
    end
  end

  // Job fields are held still by the other side until the ack toggles.
  assign start = (st_ff == SL_IDLE) && (req_s_ff ^ req_d_ff);
  assign tick = (st_ff == SL_SHIFT) && (ph_ff == '0);
  assign rising = !sclk_ff;
  assign cap = tick && op_rd_in && (rising == !op_neg_rd_in);
  assign adv = tick && op_wr_in && (rising == !op_neg_wr_in);
  assign done = tick && (edges_ff == 5'h01);
  assign nxt_rx = op_lsb_in ? {din_s_ff, rx_ff[7:1]} : {rx_ff[6:0], din_s_ff};
  assign nxt_sh = op_lsb_in ? {1'b0, sh_ff[7:1]} : {sh_ff[6:0], 1'b0};
  assign nxt_bit = op_lsb_in ? sh_ff[1] : sh_ff[6];

  // Shifter state.
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= SL_IDLE;
    end else begin
      unique case (st_ff)
        SL_IDLE: begin
          if (start) begin
            st_ff <= SL_SHIFT;
          end
        end
        SL_SHIFT: begin
          if (done) begin
            st_ff <= SL_IDLE;
          end
        end
      endcase
    end
  end

  // Half-period timer and remaining edge count, two edges per bit.
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_ff <= '0;
      edges_ff <= 5'h00;
    end else if (start) begin
      ph_ff <= PH_LOAD;
      edges_ff <= 5'({2'b00, job_bits_in} + 5'h01) << 1;
    end else if (tick) begin
      ph_ff <= PH_LOAD;
      edges_ff <= edges_ff - 5'h01;
    end else if (st_ff == SL_SHIFT) begin
      ph_ff <= ph_ff - {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // Serial clock: rests at the idle level, then inverts twice per bit.
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_ff <= 1'b0;
      lvl_ff <= 1'b0;
    end else if (st_ff == SL_IDLE) begin
      sclk_ff <= idle_s_ff;
      lvl_ff <= idle_s_ff;
    end else if (tick) begin
      sclk_ff <= !sclk_ff;
    end
  end

  // Output shift register; the pin keeps its level for read-only jobs.
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_ff <= `SSCE_BYTE_RST;
      dout_ff <= 1'b0;
    end else if (start) begin
      sh_ff <= job_data_in;
      if (op_wr_in) begin
        dout_ff <= op_lsb_in ? job_data_in[0] : job_data_in[7];
      end
    end else if (adv) begin
      sh_ff <= nxt_sh;
      dout_ff <= nxt_bit;
    end
  end

  // Input capture, only for jobs that read.
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_ff <= `SSCE_BYTE_RST;
    end else if (start) begin
      rx_ff <= `SSCE_BYTE_RST;
    end else if (cap) begin
      rx_ff <= nxt_rx;
    end
  end

  // Result word is updated with the ack toggle and then held.
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_tgl_out <= 1'b0;
      rx_byte_out <= `SSCE_BYTE_RST;
    end else if (done) begin
      ack_tgl_out <= !ack_tgl_out;
      rx_byte_out <= cap ? nxt_rx : rx_ff;
    end
  end

  assign serial_clock_out = sclk_ff;
  assign serial_data_out = dout_ff;

  default clocking cb_link @(posedge link_clk_in); endclocking
  default disable iff (!rst_n_in);

  clk_hold_a: assert property ((st_ff == SL_SHIFT && ph_ff != '0) |=> $stable(sclk_ff))
    else $error("serial clock moved between ticks");
  clk_pair_a: assert property (done |=> (sclk_ff == lvl_ff))
    else $error("serial clock did not return to its idle level");
  out_idle_a: assert property (!op_wr_in |=> $stable(dout_ff))
    else $error("data output moved during a job without write");
  first_bit_a: assert property ((start && op_wr_in) |=>
    (dout_ff == (op_lsb_in ? sh_ff[0] : sh_ff[7])))
    else $error("first data bit not presented before the clock");
  sample_edge_a: assert property ((!start && !(tick && op_rd_in &&
    (rising == !op_neg_rd_in))) |=> $stable(rx_ff))
    else $error("input captured off the selected edge");

endmodule : ssce_shifter
`default_nettype wire

// *** verilog/ssce_engine.sv ***
// Command interpreter of the serial shift command engine (top level).
// Contract
// - Each serial clock cycle inverts clock twice.
// - Idle low: change on fall, sample on rise.
// - Idle high: change on rise, sample on fall.
// - Bad opcode answers marker byte then opcode.
// - Errors only for bytes with top bit set.
// - Bits 0 and 2 pick write, read edges.
// - Bit 1 bit mode; bit 3 LSB first.
// - Bits 4,5,6 enable write, read, select; 7 zero (bit 6 opcodes with bit 7 clear are discarded here, no select).
// - Data output only when bits 7,6 clear.
// - Byte mode: 16-bit length, count is plus one.
// - Bit mode: one length byte, one to eight.
// - MSB first: bit 7 shown before first clock.
// - No capture on output-only, no drive input-only.
// - MSB byte input: first bit is MSB.
// - MSB bit input: last bit lands in bit 0.
// - MSB one-direction opcodes decode from bit fields.
// - MSB full-duplex opcodes shift both ways together.
// - LSB-first set is same encoding, bit 3.
`timescale 1ns/1ps
`default_nettype none
`include "ssce_cfg.svh"
module ssce_engine #(
  parameter int HALF_CYC = `SSCE_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire ssce_pkg::ssce_byte_t cmd_data_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  output ssce_pkg::ssce_byte_t rsp_data_out,
  output logic rsp_valid_out,
  input wire logic rsp_ready_in,
  input wire logic sclk_idle_high_in,
  input wire logic serial_data_in,
  output logic serial_clock_out,
  output logic serial_data_out,
  output logic busy_out
);
  import ssce_pkg::*;

  // A byte is a shift command when it writes or reads and touches
  // neither the top bit nor the select line; select-line opcodes are
  // not served here; with the top bit clear they fall into the silent-discard class.
  function automatic logic is_shift(input ssce_byte_t op);
    return !op[`SSCE_OP_TOP] && !op[`SSCE_OP_DO_SEL] &&
      (op[`SSCE_OP_DO_WR] || op[`SSCE_OP_DO_RD]);
  endfunction : is_shift

  ssce_state_t st_ff, nxt_st;
  ssce_byte_t op_ff, job_data_ff, rsp_data_ff, push_data;
  logic [15:0] left_ff;
  logic [2:0] job_bits_ff;
  logic req_tgl_ff, rsp_valid_ff;
  logic ack_m_ff, ack_s_ff, ack_d_ff;
  logic ack_tgl, take, slot_free, ack_seen, last;
  logic launch, push, fin, dec;
  logic bitmode, do_wr, do_rd;
  ssce_byte_t rx_byte;
  logic [15:0] len_hold_ff;
  logic [16:0] job_cnt_ff;

  assign bitmode = op_ff[`SSCE_OP_BITMODE];
  assign do_wr = op_ff[`SSCE_OP_DO_WR];
  assign do_rd = op_ff[`SSCE_OP_DO_RD];
  assign cmd_ready_out = (st_ff == SS_OP) || (st_ff == SS_LENL) ||
    (st_ff == SS_LENH) || (st_ff == SS_DATA);
  assign take = cmd_valid_in && cmd_ready_out;
  assign slot_free = !rsp_valid_ff || rsp_ready_in;
  assign ack_seen = ack_s_ff ^ ack_d_ff;
  assign last = bitmode || (left_ff == 16'h0000);

  // Next state; a payload byte is only asked for when the opcode writes.
  always_comb begin
    nxt_st = st_ff;
    launch = 1'b0;
    push = 1'b0;
    push_data = `SSCE_BYTE_RST;
    fin = 1'b0;
    dec = 1'b0;
    unique case (st_ff)
      SS_OP: begin
        if (take) begin
          if (is_shift(cmd_data_in)) begin
            nxt_st = SS_LENL;
          end else if (cmd_data_in[`SSCE_OP_TOP]) begin
            nxt_st = SS_ERR1;
          end
        end
      end
      SS_LENL: begin
        if (take) begin
          if (!bitmode) begin
            nxt_st = SS_LENH;
          end else if (do_wr) begin
            nxt_st = SS_DATA;
          end else begin
            launch = 1'b1;
            nxt_st = SS_RUN;
          end
        end
      end
      SS_LENH: begin
        if (take) begin
          if (do_wr) begin
            nxt_st = SS_DATA;
          end else begin
            launch = 1'b1;
            nxt_st = SS_RUN;
          end
        end
      end
      SS_DATA: begin
        if (take) begin
          launch = 1'b1;
          nxt_st = SS_RUN;
        end
      end
      SS_RUN: begin
        if (ack_seen) begin
          if (do_rd) begin
            nxt_st = SS_RESP;
          end else begin
            fin = 1'b1;
          end
        end
      end
      SS_RESP: begin
        if (slot_free) begin
          push = 1'b1;
          push_data = rx_byte;
          fin = 1'b1;
        end
      end
      SS_ERR1: begin
        if (slot_free) begin
          push = 1'b1;
          push_data = `SSCE_ERR_MARK;
          nxt_st = SS_ERR2;
        end
      end
      SS_ERR2: begin
        if (slot_free) begin
          push = 1'b1;
          push_data = op_ff;
          nxt_st = SS_OP;
        end
      end
    endcase
    // After each job: stop, or go on with the next byte of the count.
    if (fin) begin
      if (last) begin
        nxt_st = SS_OP;
      end else begin
        dec = 1'b1;
        if (do_wr) begin
          nxt_st = SS_DATA;
        end else begin
          launch = 1'b1;
          nxt_st = SS_RUN;
        end
      end
    end
  end

  // Interpreter state.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= SS_OP;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Opcode holding register; also the second byte of an error answer.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_ff <= `SSCE_BYTE_RST;
    end else if (take && st_ff == SS_OP) begin
      op_ff <= cmd_data_in;
    end
  end

  // Remaining byte count, low byte first then high byte.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left_ff <= 16'h0000;
    end else if (take && st_ff == SS_LENL) begin
      left_ff <= {8'h00, cmd_data_in};
    end else if (take && st_ff == SS_LENH) begin
      left_ff[15:8] <= cmd_data_in;
    end else if (dec) begin
      left_ff <= left_ff - 16'h0001;
    end
  end

  // Job word for the link side, changed only while no job is pending.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      job_bits_ff <= 3'h0;
      job_data_ff <= `SSCE_BYTE_RST;
    end else begin
      if (take && st_ff == SS_LENL) begin
        job_bits_ff <= bitmode ? cmd_data_in[2:0] : `SSCE_BYTE_BITS;
      end
      if (take && st_ff == SS_DATA) begin
        job_data_ff <= cmd_data_in;
      end
    end
  end

  // Job request toggle and ack synchroniser form a four-phase-free
  // toggle handshake; only one job is ever in flight.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_tgl_ff <= 1'b0;
      ack_m_ff <= 1'b0;
      ack_s_ff <= 1'b0;
      ack_d_ff <= 1'b0;
    end else begin
      if (launch) begin
        req_tgl_ff <= !req_tgl_ff;
      end
      ack_m_ff <= ack_tgl;
      ack_s_ff <= ack_m_ff;
      ack_d_ff <= ack_s_ff;
    end
  end

  // Single response slot; the interpreter stalls only when it must push and the slot is full.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= `SSCE_BYTE_RST;
    end else if (push) begin
      rsp_valid_ff <= 1'b1;
      rsp_data_ff <= push_data;
    end else if (rsp_ready_in) begin
      rsp_valid_ff <= 1'b0;
    end
  end

  // Helper count of jobs per command, read only by a check below.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      job_cnt_ff <= 17'h0_0000;
      len_hold_ff <= 16'h0000;
    end else if (take && st_ff == SS_OP) begin
      job_cnt_ff <= 17'h0_0000;
    end else begin
      if (launch) begin
        job_cnt_ff <= job_cnt_ff + 17'h0_0001;
      end
      if (take && st_ff == SS_LENH) begin
        len_hold_ff <= {cmd_data_in, left_ff[7:0]};
      end
    end
  end

  assign rsp_valid_out = rsp_valid_ff;
  assign rsp_data_out = rsp_data_ff;
  assign busy_out = (st_ff != SS_OP);

  ssce_shifter #(
    .HALF_CYC(HALF_CYC)
  ) u_shifter (
    .link_clk_in(link_clk_in),
    .rst_n_in(rst_n_in),
    .req_tgl_in(req_tgl_ff),
    .job_data_in(job_data_ff),
    .job_bits_in(job_bits_ff),
    .op_neg_wr_in(op_ff[`SSCE_OP_NEG_WR]),
    .op_neg_rd_in(op_ff[`SSCE_OP_NEG_RD]),
    .op_lsb_in(op_ff[`SSCE_OP_LSB]),
    .op_wr_in(do_wr),
    .op_rd_in(do_rd),
    .idle_high_in(sclk_idle_high_in),
    .serial_data_in(serial_data_in),
    .ack_tgl_out(ack_tgl),
    .rx_byte_out(rx_byte),
    .serial_clock_out(serial_clock_out),
    .serial_data_out(serial_data_out)
  );

  default clocking cb_sys @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence err_first_s;
    (st_ff == SS_ERR1) && slot_free;
  endsequence
  sequence err_mark_s;
    rsp_valid_ff && (rsp_data_ff == `SSCE_ERR_MARK) && (st_ff == SS_ERR2);
  endsequence
  sequence err_second_s;
    (st_ff == SS_ERR2) && slot_free;
  endsequence

  err_marker_a: assert property (err_first_s |=> err_mark_s)
    else $error("error marker byte not returned");
  err_echo_a: assert property (err_second_s |=>
    (rsp_valid_ff && rsp_data_ff == $past(op_ff) && st_ff == SS_OP))
    else $error("bad opcode not echoed after the marker");
  bad_detect_a: assert property ((st_ff == SS_OP && take &&
    cmd_data_in[`SSCE_OP_TOP]) |=> (st_ff == SS_ERR1))
    else $error("bad opcode with top bit set not reported");
  quiet_discard_a: assert property ((st_ff == SS_OP && take &&
    !cmd_data_in[`SSCE_OP_TOP] && !is_shift(cmd_data_in)) |=>
    (st_ff == SS_OP && $stable(rsp_data_ff) && !$rose(rsp_valid_ff)))
    else $error("byte with top bit clear was reported");
  byte_count_a: assert property ((fin && last && !bitmode) |->
    (job_cnt_ff == ({1'b0, len_hold_ff} + 17'h0_0001)))
    else $error("byte command ran the wrong number of bytes");
  bit_len_a: assert property ((st_ff == SS_LENL && take && bitmode) |=>
    (job_bits_ff == $past(cmd_data_in[2:0])))
    else $error("bit count not taken from the length byte");
  no_read_rsp_a: assert property ((st_ff == SS_RUN && ack_seen && !do_rd)
    |=> (st_ff != SS_RESP))
    else $error("output-only command returned data");

endmodule : ssce_engine
`default_nettype wire

// *** testbench/ssce_target_model.sv ***
// Behavioural serial target that shifts a byte out and records the line.
`timescale 1ns/1ps
`default_nettype none
module ssce_target_model (
  input wire logic serial_clock_out,
  input wire logic serial_data_out,
  input wire logic load_in,
  input wire logic en_in,
  input wire logic chg_rise_in,
  input wire logic [7:0] tx_in,
  output logic serial_data_in,
  output logic [15:0] cap_out,
  output logic [7:0] n_edge_out
);
  logic [7:0] sh = 8'h00;

  // Every clock edge either moves our data or captures the host's data.
  always @(posedge load_in or posedge serial_clock_out or
           negedge serial_clock_out) begin
    if (load_in) begin
      sh = tx_in;
      cap_out = 16'h0000;
      n_edge_out = 8'h00;
    end else begin
      n_edge_out = n_edge_out + 8'h01;
      if (serial_clock_out == chg_rise_in) begin
        sh = {sh[6:0], 1'b0};
      end else begin
        cap_out = {cap_out[14:0], serial_data_out};
      end
    end
  end

  // A released line shows the inverse of our last bit, never a stale copy.
  assign serial_data_in = en_in ? sh[7] : ~sh[7];
endmodule : ssce_target_model
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench of the serial shift command engine.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssce_pkg::*;
  logic clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic rst_n_in = 1'b1;
  ssce_byte_t cmd_data_in = 8'h00;
  logic cmd_valid_in = 1'b0;
  logic cmd_ready_out;
  ssce_byte_t rsp_data_out;
  logic rsp_valid_out;
  logic rsp_ready_in = 1'b0;
  logic sclk_idle_high_in = 1'b0;
  logic serial_data_in;
  logic serial_clock_out;
  logic serial_data_out;
  logic busy_out;
  logic load = 1'b0;
  logic en = 1'b0;
  logic chg_rise = 1'b0;
  ssce_byte_t tx = 8'h00;
  logic [15:0] cap;
  logic [7:0] n_edge;
  logic sdo0;
  int n_mismatch = 0;
  int compares = 0;

  // The system clock; the link clock starts off phase so edges never align.
  always #2.5 clk_in = ~clk_in;
  initial begin
    #17;
    forever #62.5 link_clk_in = ~link_clk_in;
  end

  ssce_engine #(.HALF_CYC(3)) ssce_engine_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
    .cmd_data_in(cmd_data_in), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out), .rsp_data_out(rsp_data_out),
    .rsp_valid_out(rsp_valid_out), .rsp_ready_in(rsp_ready_in),
    .sclk_idle_high_in(sclk_idle_high_in), .serial_data_in(serial_data_in),
    .serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
    .busy_out(busy_out)
  );

  ssce_target_model ssce_target_model_i (
    .serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
    .load_in(load), .en_in(en), .chg_rise_in(chg_rise), .tx_in(tx),
    .serial_data_in(serial_data_in), .cap_out(cap), .n_edge_out(n_edge)
  );

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_rsp(input ssce_byte_t got, input ssce_byte_t ex);
    compares++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, ex);
    end
  endtask : chk_rsp

  task automatic chk_wire(input logic [15:0] got, input logic [15:0] ex);
    compares++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, ex);
    end
  endtask : chk_wire

  function automatic ssce_byte_t rev8(input ssce_byte_t b);
    return {<<{b}};
  endfunction : rev8

  // Each byte is held until an edge that sees ready high takes it.
  task automatic cmd(input ssce_byte_t b[$]);
    int w;
    foreach (b[k]) begin
      cmd_data_in = b[k];
      cmd_valid_in = 1'b1;
      w = 0;
      while (cmd_ready_out !== 1'b1 && w < 20000) begin
        @(posedge clk_in);
        #1;
        w++;
      end
      if (w == 20000) n_mismatch++;
      @(posedge clk_in);
      #1;
    end
    cmd_valid_in = 1'b0;
  endtask : cmd

  // Ready stays high once raised, so back-to-back bytes are not redriven.
  task automatic get_rsp(input ssce_byte_t ex, input ssce_byte_t m);
    int w;
    w = 0;
    rsp_ready_in = 1'b1;
    while (rsp_valid_out !== 1'b1 && w < 20000) begin
      @(posedge clk_in);
      #1;
      w++;
    end
    if (w == 20000) n_mismatch++;
    chk_rsp(rsp_data_out & m, ex);
    @(posedge clk_in);
    #1;
  endtask : get_rsp

  task automatic job(input ssce_byte_t t, input logic rise);
    tx = t;
    chg_rise = rise;
    load = 1'b1;
    en = 1'b1;
    @(posedge clk_in);
    #1;
    load = 1'b0;
  endtask : job

  task automatic wait_idle;
    int w;
    w = 0;
    @(posedge clk_in);
    #1;
    while (busy_out !== 1'b0 && w < 20000) begin
      @(posedge clk_in);
      #1;
      w++;
    end
    if (w == 20000) n_mismatch++;
    en = 1'b0;
  endtask : wait_idle

  // A hang anywhere is cut short well past the expected run length.
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  // Reset falls before any edge so both domains take it; the link clock has
  // no edge inside the window, so its flops rely on the asynchronous path.
  initial begin
    #1;
    rst_n_in = 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    repeat (4) @(posedge link_clk_in);
    @(posedge clk_in);
    #1;
    // Errors are held while the host stalls, then come in order.
    sdo0 = serial_data_out;
    cmd({8'h80});
    repeat (20) @(posedge clk_in);
    #1;
    chk_rsp(rsp_data_out, 8'hFA);
    chk_wire({15'h0000, cmd_ready_out}, 16'h0000);
    chk_wire({15'h0000, busy_out}, 16'h0001);
    get_rsp(8'hFA, 8'hFF);
    get_rsp(8'h80, 8'hFF);
    wait_idle();
    cmd({8'h05, 8'h4B, 8'hC3});
    get_rsp(8'hFA, 8'hFF);
    get_rsp(8'hC3, 8'hFF);
    wait_idle();
    chk_wire({15'h0000, serial_data_out}, {15'h0000, sdo0});
    $display("test bad_opcodes done");
    // Byte write, idle low, data moves on falling edges.
    job(8'h00, 1'b0);
    cmd({8'h11, 8'h00, 8'h00, 8'hA5});
    wait_idle();
    chk_wire(cap, 16'h00A5);
    chk_wire({8'h00, n_edge}, 16'h0010);
    chk_wire({15'h0000, rsp_valid_out}, 16'h0000);
    job(8'h00, 1'b0);
    cmd({8'h19, 8'h01, 8'h00, 8'h3C, 8'h81});
    wait_idle();
    chk_wire(cap, {rev8(8'h3C), rev8(8'h81)});
    chk_wire({8'h00, n_edge}, 16'h0020);
    $display("test byte_write done");
    // Reads must leave the data line alone.
    sdo0 = serial_data_out;
    job(8'h5A, 1'b0);
    cmd({8'h20, 8'h01, 8'h00});
    get_rsp(8'h5A, 8'hFF);
    get_rsp(8'h00, 8'hFF);
    wait_idle();
    chk_wire({15'h0000, serial_data_out}, {15'h0000, sdo0});
    for (int len = 0; len < 8; len += (len == 0) ? 3 : 4) begin
      job(8'hA7, 1'b0);
      cmd({8'h22, 8'(len)});
      get_rsp(8'hA7 >> (7 - len), 8'((2 << len) - 1));
      wait_idle();
    end
    $display("test reads done");
    // Idle high: data moves on rising, sampling on falling edges.
    sclk_idle_high_in = 1'b1;
    repeat (10) @(posedge link_clk_in);
    #1;
    chk_wire({15'h0000, serial_clock_out}, 16'h0001);
    job(8'h96, 1'b1);
    cmd({8'h34, 8'h00, 8'h00, 8'hC3});
    get_rsp(8'h96, 8'hFF);
    wait_idle();
    chk_wire(cap, 16'h00C3);
    job(8'hA0, 1'b1);
    cmd({8'h3E, 8'h03, 8'h0D});
    get_rsp(8'h50, 8'hF0);
    wait_idle();
    chk_wire(cap, 16'h000B);
    chk_wire({8'h00, n_edge}, 16'h0008);
    chk_wire({15'h0000, serial_clock_out}, 16'h0001);
    $display("test duplex_idle_high done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
